// ===== common/timer_map.svh
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// Control and status register field positions, reset value and constants
`define TCR_RUN_BIT        0
`define TCR_PRESC_BIT      1
`define TCR_CLKSRC_BIT     2
`define TCR_ROLL_BIT       3
`define TCR_PINS_LO        5
`define TCR_PINS_HI        7
`define TCR_RESET_VAL      8'h00
`define TSR_ZD_BIT         0
`define PRESC_ALL_ONES     5'h1f
`define PRESC_ZERO         5'h00
`define CNT_ZERO           24'h000000
`define CNT_ONE            24'h000001
`define SEL_HIGH           2'h0
`define SEL_MID            2'h1
`define SEL_LOW            2'h2

`endif

// ===== common/timer_pkg.sv
package timer_pkg;
   typedef enum logic [1:0] {
      SRC_EXT_DIRECT = 2'b00,
      SRC_PRESC_SYS  = 2'b01,
      SRC_PRESC_EXT  = 2'b10
   } clk_src_t;
   typedef enum logic [1:0] {
      ST_HALT  = 2'b00,
      ST_ARMED = 2'b01,
      ST_RUN   = 2'b10
   } run_state_t;
endpackage : timer_pkg

// ===== verilog/prescaled_down_counter_timer.sv
`timescale 1ns/1ns
`include "timer_map.svh"

module prescaled_down_counter_timer
   import timer_pkg::*;
#(
   parameter int CNT_W = 24
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             timer_ext_input_i,
   input  wire logic [7:0]       timer_control_reg_wdata_i,
   input  wire logic             timer_control_reg_we_i,
   input  wire logic             timer_status_reg_we_i,
   input  wire logic [7:0]       timer_status_reg_wdata_i,
   input  wire logic [1:0]       preload_sel_i,
   input  wire logic             preload_we_i,
   input  wire logic [7:0]       preload_wdata_i,
   input  wire logic [1:0]       count_sel_i,
   input  wire logic             count_we_i,
   input  wire logic             timer_int_ack_i,
   input  wire logic [7:0]       timer_vector_i,
   output logic      [7:0]       timer_control_reg_o,
   output logic      [7:0]       timer_status_reg_o,
   output logic      [7:0]       preload_rdata_o,
   output logic      [7:0]       count_rdata_o,
   output logic      [CNT_W-1:0] counter_o,
   output logic                  zero_detect_flag_o,
   output logic                  timer_output_pin_o,
   output logic                  bus_transfer_ack_o,
   output logic      [7:0]       vector_o
);

   // -----------------------------------------------------------------
   // Input synchroniser and edge detect
   // -----------------------------------------------------------------
   // Third stage only remembers the previous synchronised level, so the
   // edge detector never reads the metastable first stage.
   logic sync1_q, sync2_q, sync3_q;
   logic sync1_d, sync2_d, sync3_d;
   logic ext_edge;

   always_comb begin
      sync1_d = timer_ext_input_i;
      sync2_d = sync1_q;
      sync3_d = sync2_q;
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         sync3_q <= sync3_d;
      end
   end

   assign ext_edge = sync2_q & ~sync3_q;

   // -----------------------------------------------------------------
   // Control register
   // -----------------------------------------------------------------
   logic [7:0] ctrl_q, ctrl_d;
   logic       run_en, presc_used, clk_ext, roll_mode;

   always_comb begin
      ctrl_d = ctrl_q;
      if (timer_control_reg_we_i) begin
         ctrl_d = timer_control_reg_wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_q <= `TCR_RESET_VAL;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   assign run_en     = ctrl_q[`TCR_RUN_BIT];
   assign presc_used = ctrl_q[`TCR_PRESC_BIT];
   assign clk_ext    = ctrl_q[`TCR_CLKSRC_BIT];
   assign roll_mode  = ctrl_q[`TCR_ROLL_BIT];

   // -----------------------------------------------------------------
   // Preload bytes: no reset, so reset leaves them alone
   // -----------------------------------------------------------------
   localparam int N_BYTES = CNT_W / 8;

   logic [CNT_W-1:0] preload_q, preload_d;
   logic [N_BYTES-1:0] pre_hit, cnt_hit;
   logic [7:0]         pre_byte [N_BYTES];
   logic [7:0]         cnt_byte [N_BYTES];

   // Select code 0 names the high byte, so byte b answers to N_BYTES-1-b
   for (genvar b = 0; b < N_BYTES; b++) begin : g_byte
      assign pre_hit[b]  = (preload_sel_i == 2'(N_BYTES - 1 - b));
      assign cnt_hit[b]  = (count_sel_i == 2'(N_BYTES - 1 - b));
      assign pre_byte[b] = preload_q[8*b +: 8];
      assign cnt_byte[b] = cnt_q[8*b +: 8];
   end

   // No interlock: a byte written in the cycle of a load lands afterwards
   always_comb begin
      preload_d = preload_q;
      for (int i = 0; i < N_BYTES; i++) begin
         if (preload_we_i && pre_hit[i]) begin
            preload_d[8*i +: 8] = preload_wdata_i;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      preload_q <= preload_d;
   end

   // -----------------------------------------------------------------
   // Prescaler, counter and run state
   // -----------------------------------------------------------------
   // The counter has no reset so its contents survive a reset pulse;
   // simulation starts it unknown until the first load.
   run_state_t       state_q, state_d;
   logic [4:0]       presc_q, presc_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic             zd_q, zd_d;
   logic             presc_tick, cnt_tick, zd_clear;

   // Prescaler steps on system clock or on external edges
   assign presc_tick = presc_used & (clk_ext ? ext_edge : 1'b1);
   // Counter clock: prescaler rollover or direct external edge
   assign cnt_tick = presc_used ? (presc_tick && presc_q == `PRESC_ZERO)
                                : ext_edge;
   assign zd_clear = timer_status_reg_we_i
                   & timer_status_reg_wdata_i[`TSR_ZD_BIT];

   always_comb begin
      state_d = state_q;
      presc_d = presc_q;
      cnt_d   = cnt_q;
      zd_d    = zd_q;
      if (!run_en) begin
         state_d = ST_HALT;
         presc_d = `PRESC_ALL_ONES;
         zd_d    = 1'b0;
         // Counter held
      end else begin
         if (state_q == ST_HALT) begin
            state_d = ST_ARMED;
         end
         if (presc_tick) begin
            presc_d = presc_q - 5'h01;
         end
         // Clear first, so a coincident zero event wins
         if (zd_clear) begin
            zd_d = 1'b0;
         end
         if (cnt_tick) begin
            if (state_q != ST_RUN) begin
               cnt_d   = preload_q;
               state_d = ST_RUN;
            end else if (cnt_q == `CNT_ZERO && !roll_mode) begin
               cnt_d = preload_q;
            end else begin
               cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
               if (cnt_q == `CNT_ONE) begin
                  zd_d = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= ST_HALT;
         presc_q <= `PRESC_ALL_ONES;
         zd_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         presc_q <= presc_d;
         zd_q    <= zd_d;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      cnt_q <= cnt_d;
   end

   // -----------------------------------------------------------------
   // Read paths and acknowledge
   // -----------------------------------------------------------------
   logic [7:0] pre_rd, cnt_rd;
   logic       pins_timer, ack_d;

   // Unlatched byte of the live counter; writes (count_we_i) are dropped,
   // so a read while running may tear across a decrement.
   always_comb begin
      pre_rd = 8'h00;
      cnt_rd = 8'h00;
      for (int i = 0; i < N_BYTES; i++) begin
         if (pre_hit[i]) begin
            pre_rd = pre_byte[i];
         end
         if (cnt_hit[i]) begin
            cnt_rd = cnt_byte[i];
         end
      end
   end

   // Any nonzero pin field selects timer use of the shared pins
   assign pins_timer = |ctrl_q[`TCR_PINS_HI:`TCR_PINS_LO];
   assign ack_d      = timer_int_ack_i & pins_timer & zd_q;

   // -----------------------------------------------------------------
   // Output registers
   // -----------------------------------------------------------------
   logic [7:0]       ctrl_o_d, stat_o_d, pre_o_d, cnt_o_d, vec_o_d;
   logic [CNT_W-1:0] counter_o_d;
   logic             zd_o_d, pin_o_d, ack_o_d;

   always_comb begin
      ctrl_o_d    = ctrl_q;
      stat_o_d    = {7'h00, zd_q};
      pre_o_d     = pre_rd;
      cnt_o_d     = cnt_rd;
      counter_o_d = cnt_q;
      zd_o_d      = zd_q;
      pin_o_d     = pins_timer & zd_q;
      ack_o_d     = ack_d;
      // Vector bus stays quiet unless the acknowledge is answered
      vec_o_d     = ack_d ? timer_vector_i : 8'h00;
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         timer_control_reg_o <= 8'h00;
         timer_status_reg_o  <= 8'h00;
         preload_rdata_o     <= 8'h00;
         count_rdata_o       <= 8'h00;
         counter_o           <= '0;
         zero_detect_flag_o  <= 1'b0;
         timer_output_pin_o  <= 1'b0;
         bus_transfer_ack_o  <= 1'b0;
         vector_o            <= 8'h00;
      end else begin
         timer_control_reg_o <= ctrl_o_d;
         timer_status_reg_o  <= stat_o_d;
         preload_rdata_o     <= pre_o_d;
         count_rdata_o       <= cnt_o_d;
         counter_o           <= counter_o_d;
         zero_detect_flag_o  <= zd_o_d;
         timer_output_pin_o  <= pin_o_d;
         bus_transfer_ack_o  <= ack_o_d;
         vector_o            <= vec_o_d;
      end
   end

endmodule : prescaled_down_counter_timer

// ===== verif/timer_chk_sva.sv
`timescale 1ns/1ns
module timer_chk #(
   parameter int CNT_W = 24
) (
   input wire logic             sys_clk_i,
   input wire logic             rst_b_i,
   input wire logic             timer_status_reg_we_i,
   input wire logic [7:0]       timer_status_reg_wdata_i,
   input wire logic [7:0]       timer_control_reg_o,
   input wire logic [CNT_W-1:0] counter_o,
   input wire logic             zero_detect_flag_o,
   input wire logic             bus_transfer_ack_o,
   input wire logic [7:0]       vector_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Counter is never reset, so it is trusted only once a zero was reached
   logic loaded_q = 1'b0;
   always_ff @(posedge sys_clk_i) loaded_q <= loaded_q | zero_detect_flag_o;
   wire run = timer_control_reg_o[0];
   wire clr = timer_status_reg_we_i;
   property p_halt_zd; !run [*2] |-> !zero_detect_flag_o; endproperty
   a_halt_zd: assert property (p_halt_zd) else $error("flag while halted");
   property p_hold; loaded_q && !run [*3] |-> $stable(counter_o); endproperty
   a_hold: assert property (p_hold) else $error("halted count moved");
   property p_set; run && counter_o == 1 ##1 counter_o == 0 |-> ##[0:1] zero_detect_flag_o;
   endproperty
   a_set: assert property (p_set) else $error("no flag at zero");
   property p_cause; $rose(zero_detect_flag_o) |-> counter_o == 0; endproperty
   a_cause: assert property (p_cause) else $error("flag without zero");
   property p_clr; clr && timer_status_reg_wdata_i[0] && counter_o != 1
      |-> ##2 !zero_detect_flag_o; endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   property p_keep; zero_detect_flag_o && run && clr && !timer_status_reg_wdata_i[0]
      |-> ##1 zero_detect_flag_o; endproperty
   a_keep: assert property (p_keep) else $error("flag lost");
   property p_vec; !bus_transfer_ack_o |-> vector_o == 8'h00; endproperty
   a_vec: assert property (p_vec) else $error("vector without ack");
   property p_rst; $rose(rst_b_i) |-> timer_control_reg_o == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("control not cleared");
   c_zd: cover property (zero_detect_flag_o);
   c_ack: cover property (bus_transfer_ack_o);
   c_rst: cover property ($rose(rst_b_i));
endmodule : timer_chk

bind prescaled_down_counter_timer timer_chk #(.CNT_W(CNT_W)) timer_chk_inst (
   .sys_clk_i, .rst_b_i, .timer_status_reg_we_i, .timer_status_reg_wdata_i,
   .timer_control_reg_o, .counter_o, .zero_detect_flag_o, .bus_transfer_ack_o, .vector_o);

// ===== verif/ext_pulser.sv
`timescale 1ns/1ns
module ext_pulser (
   input  wire logic clk_i,
   input  wire logic en_i,
   output logic      ext_o = 1'b0
);
   int cnt = 0;
   // Edges 40 clocks apart keep the count rate below clock over 32
   always @(negedge clk_i) begin
      cnt <= en_i ? (cnt + 1) % 40 : 0;
      ext_o <= en_i && cnt >= 20;
   end
endmodule : ext_pulser

// ===== verif/prescaled_down_counter_timer_test.sv
`timescale 1ns/1ns
module prescaled_down_counter_timer_test;
   logic sys_clk_i = 0, rst_b_i = 0, timer_control_reg_we_i = 0, timer_status_reg_we_i = 0;
   logic preload_we_i = 0, count_we_i = 0, timer_int_ack_i = 0, pulse_en = 0;
   logic [7:0] timer_control_reg_wdata_i = 0, timer_status_reg_wdata_i = 0, preload_wdata_i = 0;
   logic [7:0] timer_vector_i = 8'h5a, timer_control_reg_o, timer_status_reg_o, preload_rdata_o;
   logic [7:0] count_rdata_o, vector_o;
   logic [1:0] preload_sel_i = 0, count_sel_i = 0;
   logic [23:0] counter_o, c;
   logic timer_ext_input_i, zero_detect_flag_o, timer_output_pin_o, bus_transfer_ack_o;
   logic [9:0] rows [5] = '{10'h05a, 10'h1c3, 10'h000, 10'h100, 10'h203};
   int n_fail = 0, checks_done = 0, cyc = 0, k;
   prescaled_down_counter_timer prescaled_down_counter_timer_inst (.sys_clk_i, .rst_b_i,
      .timer_ext_input_i, .timer_control_reg_wdata_i, .timer_control_reg_we_i,
      .timer_status_reg_we_i, .timer_status_reg_wdata_i, .preload_sel_i, .preload_we_i,
      .preload_wdata_i, .count_sel_i, .count_we_i, .timer_int_ack_i, .timer_vector_i,
      .timer_control_reg_o, .timer_status_reg_o, .preload_rdata_o, .count_rdata_o, .counter_o,
      .zero_detect_flag_o, .timer_output_pin_o, .bus_transfer_ack_o, .vector_o);
   ext_pulser ext_pulser_inst (.clk_i(sys_clk_i), .en_i(pulse_en), .ext_o(timer_ext_input_i));
   // ----------------
   // Tasks
   // ----------------
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : step
   // One-hot select of control, status and preload write strobes
   task automatic wr(input logic [2:0] we, input logic [7:0] v);
      step(1);
      {timer_control_reg_we_i, timer_status_reg_we_i, preload_we_i} = we;
      timer_control_reg_wdata_i = v;
      timer_status_reg_wdata_i = v;
      preload_wdata_i = v;
      step(1);
      {timer_control_reg_we_i, timer_status_reg_we_i, preload_we_i} = 3'h0;
   endtask : wr
   task automatic wait_zd(input int lim);
      k = 0;
      while (zero_detect_flag_o !== 1'b1 && k < lim) begin
         step(1);
         k++;
      end
   endtask : wait_zd
   task automatic finish_test;
      $display("n_fail=%0d checks_done=%0d", n_fail, checks_done);
      if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   initial begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      step(10);
      rst_b_i = 1'b1;
      step(2);
      chk(timer_control_reg_o, 8'h00);
      for (int i = 0; i < 5; i++) begin
         preload_sel_i = rows[i][9:8];
         wr(3'h1, rows[i][7:0]);
         step(2);
         chk(preload_rdata_o, rows[i][7:0]);
      end
      wr(3'h4, 8'h03);
      wait_zd(200);
      chk(k >= 120 && k <= 136, 1'b1);
      chk(counter_o, 24'h0);
      chk(timer_status_reg_o, 8'h01);
      wr(3'h2, 8'hfe);
      chk(zero_detect_flag_o, 1'b1);
      wr(3'h2, 8'h01);
      step(2);
      chk(zero_detect_flag_o, 1'b0);
      wr(3'h4, 8'h00);
      step(3);
      chk(zero_detect_flag_o, 1'b0);
      c = counter_o;
      count_sel_i = 2'h2;
      count_we_i = 1'b1;
      step(1);
      count_we_i = 1'b0;
      step(40);
      chk(counter_o, c);
      chk(count_rdata_o, c[7:0]);
      wr(3'h4, 8'h03);
      step(48);
      c = counter_o;
      rst_b_i = 1'b0;
      step(2);
      rst_b_i = 1'b1;
      step(2);
      chk(timer_control_reg_o, 8'h00);
      chk(counter_o, c);
      chk(preload_rdata_o, 8'h03);
      pulse_en = 1'b1;
      wr(3'h4, 8'h01);
      wait_zd(300);
      chk(zero_detect_flag_o, 1'b1);
      wr(3'h4, 8'he1);
      timer_int_ack_i = 1'b1;
      step(3);
      chk(bus_transfer_ack_o, 1'b1);
      chk(vector_o, 8'h5a);
      chk(timer_output_pin_o, 1'b1);
      timer_int_ack_i = 1'b0;
      wr(3'h4, 8'h00);
      wr(3'h4, 8'h0b);
      wait_zd(200);
      step(34);
      chk(counter_o, 24'hffffff);
      finish_test();
   end
endmodule : prescaled_down_counter_timer_test
